/* File: design/tsc_pkg.sv */
// Package of constants, types and field layouts for the trigger sequencer.
// Functional notes
// - Clock source field picks one of eight.
// - Prescaler divides selected clock by value plus one.
// - Pulse width is field plus one clocks.
// - Watchdog off at zero, else 8 to 512.
// - Module enable turns sequencer on or off.
// - Idle-stop halts sequencer during idle mode.
// - Toggle mode inverts output instead of pulsing; code toggles on trigger steps only, broadcast still pulses.
// - Edge wait needs zero-to-one during execution.
// - Level wait completes whenever trigger bit set.
// - Edge wait completion clears trigger bit.
// - Disable clears trigger and start bits.
// - Single-step bit only visible in debug.
// - Visibility bit reads live step delay count.
// - Start runs continuously; clear halts.
// - Single step runs one command, clears start.
// - Watchdog timeout flag sticky; may clear start.
// - Busy blocks clock and prescaler writes.
// - Level input modes sample once per delay.
// - Edge input modes watch input continuously.
// - Config fields read-only while start set.
// - Broadcast pulses every enabled output.
// - Step is 4-bit code, 4-bit parameter.
// - Step lasts one clock plus step delay.
package tsc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] TSC_CTRL_OFS = 8'h00; // Control register.
    localparam logic [7:0] TSC_BTE_OFS = 8'h10; // Broadcast enables.
    localparam logic [7:0] TSC_SDLIM_OFS = 8'h20; // Step delay limit.
    localparam logic [31:0] TSC_CTRL_RST = 32'h00000000; // Control reset.
    localparam logic [31:0] TSC_BTE_RST = 32'h00000000; // Enable reset.
    localparam logic [15:0] TSC_SDLIM_RST = 16'h0000; // Delay reset.

    // ****************************************
    // Control register field positions
    // ****************************************
    localparam int TSC_CLK_LSB = 29; // Clock source select.
    localparam int TSC_DIV_LSB = 24; // Clock prescale.
    localparam int TSC_PWD_LSB = 20; // Trigger pulse width.
    localparam int TSC_WDT_LSB = 16; // Watchdog count select.
    localparam int TSC_EN_BIT = 15; // Module enable.
    localparam int TSC_SIDL_BIT = 13; // Idle stop.
    localparam int TSC_TOGL_BIT = 12; // Toggle mode.
    localparam int TSC_SWT_BIT = 10; // Software trigger.
    localparam int TSC_SSEN_BIT = 9; // Single step enable.
    localparam int TSC_IVIS_BIT = 8; // Internal visibility.
    localparam int TSC_STRT_BIT = 7; // Sequencer start.
    localparam int TSC_WDTO_BIT = 6; // Watchdog timeout flag.
    localparam int TSC_BUSY_BIT = 5; // Busy flag.
    localparam int TSC_ITM_LSB = 0; // Input trigger mode.

    // ****************************************
    // Step command codes and timing
    // ****************************************
    localparam logic [3:0] TSC_CMD_NOP = 4'h0; // Plain step.
    localparam logic [3:0] TSC_CMD_SWE = 4'h1; // Wait trigger edge.
    localparam logic [3:0] TSC_CMD_SWL = 4'h2; // Wait trigger level.
    localparam logic [3:0] TSC_CMD_TRIG = 4'h3; // Trigger output.
    localparam logic [3:0] TSC_CMD_BCST = 4'h4; // Broadcast trigger.
    localparam logic [3:0] TSC_CMD_WIN = 4'h5; // Wait input trigger.
    localparam logic [9:0] TSC_WDT_BASE = 10'h004; // Half shortest timeout.

    // Register port request.
    typedef struct packed {
        logic wr; // Write strobe.
        logic rd; // Read strobe.
        logic [7:0] addr; // Byte address.
        logic [31:0] wdata; // Write data.
    } tsc_req_t;

    // Queued step: command code and parameter.
    typedef struct packed {
        logic [3:0] code; // Command code.
        logic [3:0] param; // Parameter field.
    } tsc_step_t;

endpackage : tsc_pkg

/* File: design/tsc_core.sv */
// Control, step execution and trigger outputs of the trigger sequencer.
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module tsc_core (
    input wire logic ref_clk, // System clock, 40 MHz.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire tsc_pkg::tsc_req_t req, // Register request.
    output logic [31:0] rdata, // Read data, cycle after read.
    input wire logic [7:0] src_ticks, // Clock source enables.
    input wire logic debug_mode, // Device is in debug mode.
    input wire logic idle_mode, // Device is in idle mode.
    input wire logic step_valid, // Step command offered.
    input wire tsc_pkg::tsc_step_t step, // Offered step command.
    output logic step_ready, // Step command taken.
    input wire logic [15:0] trig_in, // Input triggers.
    output logic [31:0] trig_out // Trigger outputs.
);
    import tsc_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    typedef enum logic [1:0] {ST_FETCH, ST_EXEC, ST_DELAY} tsc_st_t;
    tsc_st_t st_q; // Sequencer state.
    logic [2:0] clk_q; // Clock source select.
    logic [4:0] div_q; // Prescale value.
    logic [3:0] pwd_q; // Pulse width.
    logic [2:0] wdt_q; // Watchdog select.
    logic en_q, sidl_q, togl_q, swt_q, ssen_q, ivis_q; // Control bits.
    logic strt_q, wdto_q, busy_q; // Start, timeout and busy.
    logic [1:0] itm_q; // Input trigger mode.
    logic [31:0] bte_q; // Broadcast enables.
    logic [15:0] sdlim_q; // Step delay limit.
    logic [15:0] sd_cnt_q; // Live step delay counter.
    logic [4:0] div_cnt_q; // Prescale counter.
    logic [9:0] wdt_cnt_q; // Watchdog counter.
    logic [3:0] pw_cnt_q; // Pulse width counter.
    logic [31:0] pulse_q; // Outputs in pulse.
    logic [31:0] tog_q; // Toggled output levels.
    logic [31:0] rdata_q; // Registered read data.
    logic swt_prev_q; // Trigger bit seen at last tick.
    logic in_prev_q; // Selected input at last tick.
    tsc_step_t cmd_q; // Command in execution.
    logic seq_tick; // One sequencer clock.
    logic run_tick; // Sequencer clock while running.
    logic ctl_wr, bte_wr, sd_wr; // Write decodes.
    logic done_now, delay_now, finish; // Step progress.
    logic wdt_fire; // Watchdog expiry.
    logic trig_in_sel; // Selected input trigger.
    logic sstep_eff; // Single step in effect.

    // Timeout in sequencer clocks for a nonzero select code.
    function automatic logic [9:0] wdt_limit(input logic [2:0] s);
        wdt_limit = TSC_WDT_BASE << s;
    endfunction : wdt_limit

    // ****************************************
    // Register decode
    // ****************************************
    assign ctl_wr = req.wr && (req.addr == TSC_CTRL_OFS);
    assign bte_wr = req.wr && (req.addr == TSC_BTE_OFS);
    assign sd_wr = req.wr && (req.addr == TSC_SDLIM_OFS);
    assign sstep_eff = ssen_q && debug_mode;
    assign trig_in_sel = trig_in[cmd_q.param];

    // ****************************************
    // Sequencer clock
    // ****************************************
    // Prescale counter advances on each tick of the chosen source.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt_q <= 5'h00;
        end else if (src_ticks[clk_q]) begin
            if (div_cnt_q == div_q) begin
                div_cnt_q <= 5'h00;
            end else begin
                div_cnt_q <= div_cnt_q + 5'h01;
            end
        end
    end

    assign seq_tick = src_ticks[clk_q] && (div_cnt_q == div_q);
    assign run_tick = seq_tick && en_q && !(sidl_q && idle_mode);

    // ****************************************
    // Step execution
    // ****************************************
    // fetch step when started.
    assign step_ready = run_tick && strt_q && (st_q == ST_FETCH);

    // Decides whether the current command is finished in this clock.
    always_comb begin
        done_now = 1'b0;
        delay_now = 1'b0;
        if (run_tick && st_q == ST_EXEC) begin
            case (cmd_q.code)
                TSC_CMD_SWE: begin
                    done_now = swt_q && !swt_prev_q;
                    delay_now = done_now;
                end
                TSC_CMD_SWL: begin
                    done_now = swt_q;
                    delay_now = done_now;
                end
                TSC_CMD_WIN: begin
                    if (itm_q[1]) begin
                        done_now = trig_in_sel && (sd_cnt_q == 16'h0000);
                    end else begin
                        done_now = trig_in_sel && !in_prev_q;
                    end
                    delay_now = done_now && !itm_q[0];
                end
                default: begin
                    done_now = 1'b1;
                    delay_now = 1'b1;
                end
            endcase
        end
    end

    assign wdt_fire = run_tick && (st_q == ST_EXEC) && (wdt_q != 3'h0) &&
        !done_now && (wdt_cnt_q == wdt_limit(wdt_q) - 10'h001);
    assign finish = run_tick && (
        (st_q == ST_EXEC && done_now &&
            !(delay_now && sdlim_q != 16'h0000)) ||
        (st_q == ST_DELAY && sd_cnt_q == sdlim_q - 16'h0001));

    // State machine of the step sequencer.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= ST_FETCH;
        end else if (!en_q || (!strt_q && st_q != ST_DELAY)) begin
            st_q <= ST_FETCH;
        end else if (run_tick) begin
            case (st_q)
                ST_FETCH: begin
                    if (step_valid && strt_q) begin
                        st_q <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (wdt_fire || finish) begin
                        st_q <= ST_FETCH;
                    end else if (done_now) begin
                        st_q <= ST_DELAY;
                    end
                end
                ST_DELAY: begin
                    if (finish) begin
                        st_q <= ST_FETCH;
                    end
                end
                default: begin
                    st_q <= ST_FETCH;
                end
            endcase
        end
    end

    // Latches the step taken from the queue.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_q <= '0;
        end else if (step_ready && step_valid) begin
            cmd_q <= step;
        end
    end

    // Step delay counter; level input modes wrap it while waiting.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sd_cnt_q <= 16'h0000;
        end else if (!run_tick) begin
            sd_cnt_q <= sd_cnt_q;
        end else if (st_q == ST_FETCH || finish || done_now) begin
            sd_cnt_q <= 16'h0000;
        end else if (sd_cnt_q >= sdlim_q) begin
            sd_cnt_q <= 16'h0000;
        end else begin
            sd_cnt_q <= sd_cnt_q + 16'h0001;
        end
    end

    // watchdog counts clocks spent in one command.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wdt_cnt_q <= 10'h000;
        end else if (st_q != ST_EXEC) begin
            wdt_cnt_q <= 10'h000;
        end else if (run_tick) begin
            wdt_cnt_q <= wdt_cnt_q + 10'h001;
        end
    end

    // Edge history of the trigger bit and the selected input.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            swt_prev_q <= 1'b0;
            in_prev_q <= 1'b0;
        end else if (run_tick) begin
            swt_prev_q <= swt_q;
            in_prev_q <= trig_in_sel;
        end
    end

    // ****************************************
    // Trigger outputs
    // ****************************************
    // Pulses share one width counter; a new trigger restarts it.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pulse_q <= 32'h00000000;
            pw_cnt_q <= 4'h0;
            tog_q <= 32'h00000000;
        end else if (!en_q) begin
            pulse_q <= 32'h00000000;
            pw_cnt_q <= 4'h0;
        end else if (run_tick && st_q == ST_EXEC &&
            cmd_q.code == TSC_CMD_TRIG && togl_q) begin
            tog_q[cmd_q.param] <= !tog_q[cmd_q.param];
        end else if (run_tick && st_q == ST_EXEC &&
            (cmd_q.code == TSC_CMD_TRIG || cmd_q.code == TSC_CMD_BCST)) begin
            if (cmd_q.code == TSC_CMD_BCST) begin
                pulse_q <= pulse_q | bte_q;
            end else begin
                pulse_q[cmd_q.param] <= 1'b1;
            end
            pw_cnt_q <= 4'h0;
        end else if (seq_tick && pulse_q != 32'h00000000) begin
            // end pulse after width plus one.
            if (pw_cnt_q == pwd_q) begin
                pulse_q <= 32'h00000000;
                pw_cnt_q <= 4'h0;
            end else begin
                pw_cnt_q <= pw_cnt_q + 4'h1;
            end
        end
    end

    assign trig_out = pulse_q | tog_q;

    // ****************************************
    // Control register
    // ****************************************
    // Configuration fields; clock fields lock while busy.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_q <= TSC_CTRL_RST[TSC_CLK_LSB +: 3];
            div_q <= TSC_CTRL_RST[TSC_DIV_LSB +: 5];
            pwd_q <= TSC_CTRL_RST[TSC_PWD_LSB +: 4];
            wdt_q <= TSC_CTRL_RST[TSC_WDT_LSB +: 3];
            togl_q <= TSC_CTRL_RST[TSC_TOGL_BIT];
            ivis_q <= TSC_CTRL_RST[TSC_IVIS_BIT];
            itm_q <= TSC_CTRL_RST[TSC_ITM_LSB +: 2];
            en_q <= TSC_CTRL_RST[TSC_EN_BIT];
            sidl_q <= TSC_CTRL_RST[TSC_SIDL_BIT];
            ssen_q <= TSC_CTRL_RST[TSC_SSEN_BIT];
        end else if (ctl_wr) begin
            en_q <= req.wdata[TSC_EN_BIT];
            sidl_q <= req.wdata[TSC_SIDL_BIT];
            // single step written only in debug.
            if (debug_mode) begin
                ssen_q <= req.wdata[TSC_SSEN_BIT];
            end
            if (!busy_q && !strt_q) begin
                clk_q <= req.wdata[TSC_CLK_LSB +: 3];
                div_q <= req.wdata[TSC_DIV_LSB +: 5];
            end
            if (!strt_q) begin
                pwd_q <= req.wdata[TSC_PWD_LSB +: 4];
                wdt_q <= req.wdata[TSC_WDT_LSB +: 3];
                togl_q <= req.wdata[TSC_TOGL_BIT];
                ivis_q <= req.wdata[TSC_IVIS_BIT];
                itm_q <= req.wdata[TSC_ITM_LSB +: 2];
            end
        end
    end

    // Software trigger bit; setting wins over a hardware clear.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            swt_q <= TSC_CTRL_RST[TSC_SWT_BIT];
        end else if (!en_q) begin
            swt_q <= 1'b0;
        end else if (ctl_wr && req.wdata[TSC_SWT_BIT]) begin
            swt_q <= 1'b1;
        end else if (finish && cmd_q.code == TSC_CMD_SWE) begin
            swt_q <= 1'b0;
        end
    end

    // Start bit with hardware clears.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            strt_q <= TSC_CTRL_RST[TSC_STRT_BIT];
        end else if (!en_q) begin
            strt_q <= 1'b0;
        end else if (ctl_wr) begin
            strt_q <= req.wdata[TSC_STRT_BIT];
        end else if (wdt_fire) begin
            strt_q <= 1'b0;
        end else if (finish && sstep_eff) begin
            strt_q <= 1'b0;
        end
    end

    // sticky timeout flag; hardware set wins.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wdto_q <= TSC_CTRL_RST[TSC_WDTO_BIT];
        end else if (wdt_fire) begin
            wdto_q <= 1'b1;
        end else if (!en_q || (ctl_wr && !req.wdata[TSC_WDTO_BIT])) begin
            wdto_q <= 1'b0;
        end
    end

    // busy while enabled or a step is unfinished.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= en_q || (st_q != ST_FETCH) || (pulse_q != 32'h0);
        end
    end

    // Broadcast enable and step delay limit registers.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            bte_q <= TSC_BTE_RST;
            sdlim_q <= TSC_SDLIM_RST;
        end else begin
            if (bte_wr) begin
                bte_q <= req.wdata;
            end
            if (sd_wr && !strt_q) begin
                sdlim_q <= req.wdata[15:0];
            end
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    // Read data stands only in the cycle after the read strobe.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 32'h00000000;
        end else if (!req.rd) begin
            rdata_q <= 32'h00000000;
        end else begin
            case (req.addr)
                TSC_CTRL_OFS: begin
                    rdata_q <= {clk_q, div_q, pwd_q, 1'b0, wdt_q, en_q,
                        1'b0, sidl_q, togl_q, 1'b0, swt_q,
                        sstep_eff, ivis_q, strt_q, wdto_q, busy_q,
                        3'h0, itm_q};
                end
                TSC_BTE_OFS: begin
                    rdata_q <= bte_q;
                end
                TSC_SDLIM_OFS: begin
                    rdata_q <= {16'h0000, ivis_q ? sd_cnt_q : sdlim_q};
                end
                default: begin
                    rdata_q <= 32'h00000000;
                end
            endcase
        end
    end

    assign rdata = rdata_q;

    // ****************************************
    // Assertions
    // ****************************************
    sequence ctl_write_s;
        ctl_wr ##1 1'b1;
    endsequence

    div_ratio_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        seq_tick |=> div_cnt_q == 5'h00)
        else $error("Prescale count did not restart after a tick");
    clk_lock_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (busy_q && ctl_wr) |=> $stable(clk_q) && $stable(div_q))
        else $error("Clock fields changed while busy");
    ro_fields_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (strt_q && ctl_wr) |=> $stable(pwd_q) && $stable(itm_q))
        else $error("Locked field changed while started");
    dis_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !en_q |=> !swt_q && !strt_q)
        else $error("Disable left trigger or start set");
    wdt_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wdt_fire |=> wdto_q && !strt_q && st_q == ST_FETCH)
        else $error("Watchdog expiry not flagged");
    wdt_off_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wdt_q == 3'h0 |-> !wdt_fire)
        else $error("Watchdog fired while disabled");
    ssen_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (req.rd && req.addr == TSC_CTRL_OFS && !debug_mode)
        |=> !rdata[TSC_SSEN_BIT])
        else $error("Single step visible outside debug");
    swe_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (finish && cmd_q.code == TSC_CMD_SWE && !ctl_wr) |=> !swt_q)
        else $error("Edge wait left trigger bit set");
    swt_set_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (ctl_write_s and (en_q && req.wdata[TSC_SWT_BIT]) ##1 1'b1)
        |-> swt_q)
        else $error("Trigger write of one was lost");
    pulse_width_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        pulse_q != 32'h0 |-> pw_cnt_q <= pwd_q)
        else $error("Pulse ran past its width");
    sstep_halt_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (finish && sstep_eff && !ctl_wr) |=> !strt_q)
        else $error("Single step did not halt");

endmodule : tsc_core

/* File: test/tsc_partner.sv */
// Peripheral-side model that offers queued steps and holds the input triggers at zero.
`timescale 1ns/1ps
module tsc_partner (
    input wire logic ref_clk, // System clock.
    input wire logic rst_b, // Reset, active low.
    input wire logic step_ready, // Step taken by the block.
    output logic step_valid, // Step offered.
    output tsc_pkg::tsc_step_t step, // Offered step.
    output logic [15:0] trig_in // Input triggers.
);
    import tsc_pkg::*;
    logic [7:0] q[$]; // Steps waiting to be offered.

    // Adds one step to the back of the offer queue.
    task automatic push(input logic [7:0] s);
        q.push_back(s);
    endtask : push

    // whole steps
    // Holds each step until taken; idle lines flip so stale data never pass.
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            step_valid <= 1'b0;
            step <= '0;
            trig_in <= 16'h0000;
        end else begin
            if (step_valid && step_ready) begin
                void'(q.pop_front());
            end
            step_valid <= (q.size() != 0);
            step <= (q.size() != 0) ? q[0] : ~step;
        end
    end
endmodule : tsc_partner

/* File: test/testbench.sv */
// Self-checking bench for the trigger sequencer control block.
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin mismatches++; \
$display("ERROR %s exp %h got %h", n, e, s); end end
module testbench;
    import tsc_pkg::*;
    logic ref_clk = 0, rst_b = 0, debug_mode = 0, idle_mode = 0;
    logic step_valid, step_ready;
    logic [7:0] src_ticks = 8'hff; // Every source ticks each cycle.
    logic [15:0] trig_in;
    logic [31:0] rdata, trig_out, r;
    tsc_req_t req = '0;
    tsc_step_t step;
    int mismatches = 0, num_checks = 0, cyc = 0, n;
    tsc_core dut (.ref_clk(ref_clk), .rst_b(rst_b), .req(req), .rdata(rdata),
        .src_ticks(src_ticks), .debug_mode(debug_mode), .idle_mode(idle_mode),
        .step_valid(step_valid), .step(step), .step_ready(step_ready),
        .trig_in(trig_in), .trig_out(trig_out));
    tsc_partner p (.ref_clk(ref_clk), .rst_b(rst_b), .step_ready(step_ready),
        .step_valid(step_valid), .step(step), .trig_in(trig_in));
    always #12.5 ref_clk = ~ref_clk;
    // Cuts a hung run short after a fixed number of cycles.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk) req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
        @(posedge ref_clk) req <= '0;
        #1 r = rdata;
    endtask : rd
    // Reset values, readback and an unmapped address.
    task automatic t_regs();
        rd(TSC_CTRL_OFS); `CHK("ctrl", TSC_CTRL_RST, r)
        rd(TSC_BTE_OFS); `CHK("bte", TSC_BTE_RST, r)
        wr(TSC_BTE_OFS, 32'h0000a5a5); rd(TSC_BTE_OFS);
        `CHK("bte rw", 32'h0000a5a5, r)
        rd(8'h40); `CHK("unmapped", 32'h0, r)
    endtask : t_regs
    // Single-step bit is written only in debug and kept outside it.
    task automatic t_ssen();
        wr(TSC_CTRL_OFS, 32'h200); debug_mode <= 1; rd(TSC_CTRL_OFS);
        `CHK("ssen nodbg", 1'b0, r[TSC_SSEN_BIT])
        wr(TSC_CTRL_OFS, 32'h200); rd(TSC_CTRL_OFS);
        `CHK("ssen dbg", 1'b1, r[TSC_SSEN_BIT])
        debug_mode <= 0; wr(TSC_CTRL_OFS, 32'h0); rd(TSC_CTRL_OFS);
        `CHK("ssen hid", 1'b0, r[TSC_SSEN_BIT])
        debug_mode <= 1; rd(TSC_CTRL_OFS);
        `CHK("ssen kept", 1'b1, r[TSC_SSEN_BIT])
        wr(TSC_CTRL_OFS, 32'h0); debug_mode <= 0;
    endtask : t_ssen
    // Zero write leaves the software trigger; disable clears it.
    task automatic t_swt();
        wr(TSC_CTRL_OFS, 32'h8000); wr(TSC_CTRL_OFS, 32'h8400);
        wr(TSC_CTRL_OFS, 32'h8080);
        rd(TSC_CTRL_OFS); `CHK("swt kept", 1'b1, r[TSC_SWT_BIT])
        wr(TSC_CTRL_OFS, 32'h0); rd(TSC_CTRL_OFS);
        `CHK("swt off", 2'b00, {r[TSC_SWT_BIT], r[TSC_STRT_BIT]})
    endtask : t_swt
    // Pulse width, read-only fields while running, and broadcast mask.
    task automatic t_pulse();
        wr(TSC_CTRL_OFS, 32'h00208000); wr(TSC_CTRL_OFS, 32'h00208080);
        wr(TSC_CTRL_OFS, 32'h00508080); rd(TSC_CTRL_OFS);
        `CHK("pwd locked", 4'h2, r[23:20])
        p.push({TSC_CMD_TRIG, 4'h5}); n = 0;
        for (int i = 0; i < 50 && trig_out[5] !== 1'b1; i++) @(negedge ref_clk);
        while (trig_out[5] === 1'b1 && n < 40) begin
            n++;
            @(negedge ref_clk);
        end
        `CHK("pulse width", 3, n)
        p.push({TSC_CMD_BCST, 4'h0});
        for (int i = 0; i < 50 && trig_out === 32'h0; i++) @(negedge ref_clk);
        `CHK("broadcast", 32'h0000a5a5, trig_out)
    endtask : t_pulse
    // Software trigger waits, toggle mode and the step watchdog.
    task automatic t_wait();
        p.push({TSC_CMD_SWE, 4'h0});
        repeat (4) @(posedge ref_clk);
        wr(TSC_CTRL_OFS, 32'h00208480); rd(TSC_CTRL_OFS);
        `CHK("swe clear", 1'b0, r[TSC_SWT_BIT])
        p.push({TSC_CMD_SWL, 4'h0}); p.push({TSC_CMD_TRIG, 4'h1});
        repeat (4) @(posedge ref_clk);
        wr(TSC_CTRL_OFS, 32'h00208480); rd(TSC_CTRL_OFS);
        `CHK("swl keep", 1'b1, r[TSC_SWT_BIT])
        for (int i = 0; i < 20 && trig_out[1] !== 1'b1; i++)
            @(negedge ref_clk);
        `CHK("swl done", 1'b1, trig_out[1])
        p.push({TSC_CMD_SWE, 4'h0}); p.push({TSC_CMD_TRIG, 4'h3}); n = 0;
        repeat (12) begin
            @(negedge ref_clk);
            n += trig_out[3];
        end
        `CHK("swe stale", 0, n)
        wr(TSC_CTRL_OFS, 32'h0); wr(TSC_CTRL_OFS, 32'h00019000);
        wr(TSC_CTRL_OFS, 32'h00019080); repeat (6) @(negedge ref_clk);
        `CHK("toggle on", 1'b1, trig_out[3])
        p.push({TSC_CMD_TRIG, 4'h3}); repeat (6) @(negedge ref_clk);
        `CHK("toggle off", 1'b0, trig_out[3])
        p.push({TSC_CMD_SWL, 4'h0}); repeat (20) @(posedge ref_clk);
        rd(TSC_CTRL_OFS);
        `CHK("wdt", 2'b10, {r[TSC_WDTO_BIT], r[TSC_STRT_BIT]})
    endtask : t_wait
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_b <= 1;
        t_regs();
        t_ssen();
        t_swt();
        t_pulse();
        t_wait();
        report_and_stop();
    end
endmodule : testbench
